// ### design/pcacv_top.sv
// byte access path to channel 1 and 2 capture/compare and auto-reload values
// Summary of operation
// - low byte register holds bits 7:0 of the 16-bit value, readable
// - channel 1 high byte register holds bits 15:8 of the 16-bit value, readable
// - same addresses can reach auto-reload value bytes for 9-11 bit PWM
// - reload view select steers access to compare or reload value
// - writing a low byte clears that channel's comparator enable
// - writing the channel 1 high byte sets channel 1's comparator enable
// - comparator enable bit turns on the channel's counter compare
// - wide PWM select: 0 gives 8-11 bit, 1 gives 16-bit PWM
module pcacv_top
  import pcacv_pkg::*;
(
  input  wire logic                     ref_clk,                // system clock, 100 MHz
  input  wire logic                     rst_n,                  // async reset, active low
  input  wire pcacv_pkg::pcacv_sfr_req_type sfr_req,            // sfr bus request
  output pcacv_pkg::pcacv_sfr_rsp_type  sfr_rsp,                // sfr read answer
  input  wire logic                     reload_view_select,     // from pwm configuration register
  input  wire logic [7:0]               chan1_mode,             // channel 1 mode register
  input  wire logic [7:0]               chan2_mode,             // channel 2 mode register
  output logic      [15:0]              chan1_compare_value,    // channel 1 compare value
  output logic      [15:0]              chan1_reload_value,     // channel 1 auto-reload value
  output logic      [15:0]              chan2_compare_value,    // channel 2 compare value
  output logic      [15:0]              chan2_reload_value,     // channel 2 auto-reload value
  output logic                          chan1_enable_clear,     // pulse: clear channel 1 enable
  output logic                          chan1_enable_set,       // pulse: set channel 1 enable
  output logic                          chan2_enable_clear,     // pulse: clear channel 2 enable
  output logic                          chan1_comparator_active, // channel 1 compare running
  output logic                          chan2_comparator_active  // channel 2 compare running
);
  import pcacv_pkg::*;

  logic [1:0] chan1_write;
  logic [1:0] chan2_write;
  logic       chan1_reload;
  logic       chan2_reload;
  logic [15:0] chan1_view;
  logic [15:0] chan2_view;
  logic [7:0] next_rdata;
  logic       next_hit;

  function automatic logic [1:0] decode_write(input pcacv_sfr_req_type req,
                                              input logic [7:0] low_addr,
                                              input logic [7:0] high_addr);
    logic [1:0] kind;
    kind = WRITE_NONE;
    if (req.wr && req.addr == low_addr)
    begin
      kind = WRITE_LOW;
    end
    else if (req.wr && req.addr == high_addr)
    begin
      kind = WRITE_HIGH;
    end
    return kind;
  endfunction : decode_write

  // reload view only applies in the narrow pwm widths
  function automatic logic reload_active(input logic [7:0] mode, input logic sel);
    return sel && mode[PWM_ENABLE_BIT] && !mode[WIDE_PWM_SELECT_BIT];
  endfunction : reload_active

  // channel 2 high byte lives elsewhere; repeating the low address keeps its high decode dead
  assign chan1_write  = decode_write(sfr_req, CHAN1_VALUE_LOW_ADDR, CHAN1_VALUE_HIGH_ADDR);
  assign chan2_write  = decode_write(sfr_req, CHAN2_VALUE_LOW_ADDR, CHAN2_VALUE_LOW_ADDR);
  assign chan1_reload = reload_active(chan1_mode, reload_view_select);
  assign chan2_reload = reload_active(chan2_mode, reload_view_select);

  pcacv_channel u_chan1 (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .use_reload    (chan1_reload),
    .write_low     (chan1_write == WRITE_LOW),
    .write_high    (chan1_write == WRITE_HIGH),
    .wdata         (sfr_req.wdata),
    .compare_value (chan1_compare_value),
    .reload_value  (chan1_reload_value),
    .enable_clear  (chan1_enable_clear),
    .enable_set    (chan1_enable_set)
  );

  pcacv_channel u_chan2 (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .use_reload    (chan2_reload),
    .write_low     (chan2_write == WRITE_LOW),
    .write_high    (1'b0),
    .wdata         (sfr_req.wdata),
    .compare_value (chan2_compare_value),
    .reload_value  (chan2_reload_value),
    .enable_clear  (chan2_enable_clear),
    .enable_set    ()
  );

  assign chan1_view = chan1_reload ? chan1_reload_value : chan1_compare_value;
  assign chan2_view = chan2_reload ? chan2_reload_value : chan2_compare_value;

  always_comb
  begin
    next_rdata = BYTE_RESET;
    next_hit   = 1'b0;
    if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        CHAN1_VALUE_LOW_ADDR:
        begin
          next_rdata = chan1_view[7:0];
          next_hit   = 1'b1;
        end
        CHAN1_VALUE_HIGH_ADDR:
        begin
          next_rdata = chan1_view[15:8];
          next_hit   = 1'b1;
        end
        CHAN2_VALUE_LOW_ADDR:
        begin
          next_rdata = chan2_view[7:0];
          next_hit   = 1'b1;
        end
        default:
        begin
          next_rdata = BYTE_RESET;
          next_hit   = 1'b0;
        end
      endcase
    end
  end

  // registered read data: answer one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rsp <= '0;
    end
    else
    begin
      sfr_rsp.rdata <= next_rdata;
      sfr_rsp.hit   <= next_hit;
    end
  end

  // the enable bit itself sits in the mode register outside; this mirrors its effect
  assign chan1_comparator_active = chan1_mode[COMPARATOR_ENABLE_BIT];
  assign chan2_comparator_active = chan2_mode[COMPARATOR_ENABLE_BIT];

  a_low_write_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == CHAN1_VALUE_LOW_ADDR |-> chan1_enable_clear && !chan1_enable_set)
    else $error("low byte write did not clear enable");

  a_high_write_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == CHAN1_VALUE_HIGH_ADDR |-> chan1_enable_set && !chan1_enable_clear)
    else $error("high byte write did not set enable");

  a_chan2_low_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chan2_enable_clear == (sfr_req.wr && sfr_req.addr == CHAN2_VALUE_LOW_ADDR))
    else $error("channel 2 enable clear mismatch");

  a_low_stores_compare: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == CHAN1_VALUE_LOW_ADDR && !chan1_reload
    |=> chan1_compare_value[7:0] == $past(sfr_req.wdata)
        && $stable(chan1_reload_value))
    else $error("low byte not stored in compare value");

  a_high_stores_compare: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == CHAN1_VALUE_HIGH_ADDR && !chan1_reload
    |=> chan1_compare_value[15:8] == $past(sfr_req.wdata))
    else $error("high byte not stored in compare value");

  a_reload_view_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == CHAN1_VALUE_HIGH_ADDR && chan1_reload
    |=> chan1_reload_value[15:8] == $past(sfr_req.wdata)
        && $stable(chan1_compare_value))
    else $error("reload view write misrouted");

  a_wide_pwm_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chan2_mode[WIDE_PWM_SELECT_BIT] |-> !chan2_reload)
    else $error("reload view active in 16-bit pwm");

  a_read_reload_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.rd && sfr_req.addr == CHAN2_VALUE_LOW_ADDR && chan2_reload
    |=> sfr_rsp.hit && sfr_rsp.rdata == $past(chan2_reload_value[7:0]))
    else $error("reload byte read wrong");

  a_read_compare_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sfr_req.rd && sfr_req.addr == CHAN1_VALUE_HIGH_ADDR && !chan1_reload
    |=> sfr_rsp.hit && sfr_rsp.rdata == $past(chan1_compare_value[15:8]))
    else $error("compare byte read wrong");

  a_enable_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chan1_comparator_active == chan1_mode[COMPARATOR_ENABLE_BIT])
    else $error("comparator active mismatch");

  // a byte transfer is taken on one edge and shows on the next
  sequence s_chan2_low_write;
    sfr_req.wr && sfr_req.addr == CHAN2_VALUE_LOW_ADDR;
  endsequence

  sequence s_chan1_low_read;
    sfr_req.rd && sfr_req.addr == CHAN1_VALUE_LOW_ADDR;
  endsequence

  a_chan2_compare_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_chan2_low_write ##0 !chan2_reload
    |=> chan2_compare_value[7:0] == $past(sfr_req.wdata) && $stable(chan2_reload_value))
    else $error("channel 2 low byte not stored in compare value");

  a_chan2_reload_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_chan2_low_write ##0 chan2_reload
    |=> chan2_reload_value[7:0] == $past(sfr_req.wdata) && $stable(chan2_compare_value))
    else $error("channel 2 low byte not stored in reload value");

  a_read_reload_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_chan1_low_read ##0 chan1_reload
    |=> sfr_rsp.hit && sfr_rsp.rdata == $past(chan1_reload_value[7:0]))
    else $error("channel 1 reload low byte read wrong");

  a_read_compare_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_chan1_low_read ##0 !chan1_reload
    |=> sfr_rsp.hit && sfr_rsp.rdata == $past(chan1_compare_value[7:0]))
    else $error("channel 1 compare low byte read wrong");

  // without a read strobe the answer must stay quiet, so stale bytes never leak
  a_idle_read_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sfr_req.rd |=> !sfr_rsp.hit && sfr_rsp.rdata == BYTE_RESET)
    else $error("read answer present without a read");
endmodule : pcacv_top

// ### design/pcacv_pkg.sv
// package: offsets, field positions and reset values of the capture value byte registers
package pcacv_pkg;
  localparam logic [7:0] CHAN1_VALUE_LOW_ADDR  = 8'hE9;
  localparam logic [7:0] CHAN1_VALUE_HIGH_ADDR = 8'hEA;
  localparam logic [7:0] CHAN2_VALUE_LOW_ADDR  = 8'hEB;
  localparam logic [7:0] BYTE_RESET            = 8'h00;
  localparam int         WIDE_PWM_SELECT_BIT   = 7;
  localparam int         COMPARATOR_ENABLE_BIT = 6;
  localparam int         PWM_ENABLE_BIT        = 1;
  localparam logic [1:0] WRITE_NONE            = 2'h0;
  localparam logic [1:0] WRITE_LOW             = 2'h1;
  localparam logic [1:0] WRITE_HIGH            = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcacv_sfr_req_type;

  typedef struct packed {
    logic       hit;
    logic [7:0] rdata;
  } pcacv_sfr_rsp_type;
endpackage : pcacv_pkg

// ### design/pcacv_channel.sv
// one channel: compare value and auto-reload value, byte writes and enable side effects
module pcacv_channel
  import pcacv_pkg::*;
(
  input  wire logic        ref_clk,       // system clock
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic        use_reload,    // accesses go to the reload value
  input  wire logic        write_low,     // software write to low byte
  input  wire logic        write_high,    // software write to high byte
  input  wire logic [7:0]  wdata,         // write byte
  output logic      [15:0] compare_value, // capture/compare value
  output logic      [15:0] reload_value,  // auto-reload value
  output logic             enable_clear,  // pulse: force comparator enable to 0
  output logic             enable_set     // pulse: force comparator enable to 1
);
  import pcacv_pkg::*;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_value <= {BYTE_RESET, BYTE_RESET};
    end
    else if (!use_reload && write_low)
    begin
      compare_value[7:0] <= wdata;
    end
    else if (!use_reload && write_high)
    begin
      compare_value[15:8] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_value <= {BYTE_RESET, BYTE_RESET};
    end
    else if (use_reload && write_low)
    begin
      reload_value[7:0] <= wdata;
    end
    else if (use_reload && write_high)
    begin
      reload_value[15:8] <= wdata;
    end
  end

  // enable side effects happen whichever value the write reached
  assign enable_clear = write_low;
  assign enable_set   = write_high;
endmodule : pcacv_channel

// ### verif/pcacv_top_tb.sv
// testbench: byte access to channel compare and auto-reload values
module pcacv_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pcacv_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       rvs;
    logic [7:0] mode;
    logic [2:0] pulses; // {chan2 clear, chan1 set, chan1 clear}
  } pcacv_row_type;
  logic              ref_clk;
  logic              rst_n;
  logic              rvs;
  logic [7:0]        mode1;
  logic [7:0]        mode2;
  pcacv_sfr_req_type req;
  pcacv_sfr_rsp_type rsp;
  logic [15:0]       c1, r1, c2, r2;
  logic              clr1, set1, clr2, act1, act2;
  logic [15:0]       cmp [2];
  logic [15:0]       rld [2];
  logic              view, hi;
  int                idx;
  int                bad_count;
  int                n_tests;
  pcacv_row_type     rows [9] = '{
    '{8'hE9, 8'h5A, 1'h0, 8'h00, 3'h1}, '{8'hEA, 8'hA5, 1'h0, 8'h00, 3'h2},
    '{8'hEB, 8'h3C, 1'h0, 8'h40, 3'h4}, '{8'hE9, 8'h11, 1'h1, 8'h02, 3'h1},
    '{8'hEA, 8'h22, 1'h1, 8'h02, 3'h2}, '{8'hEB, 8'h33, 1'h1, 8'h02, 3'h4},
    '{8'hE9, 8'hFF, 1'h1, 8'h82, 3'h1}, '{8'hEA, 8'h0F, 1'h1, 8'h40, 3'h2},
    '{8'hE9, 8'hC3, 1'h0, 8'h42, 3'h1}};

  pcacv_top u_pcacv_top (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(req), .sfr_rsp(rsp),
    .reload_view_select(rvs), .chan1_mode(mode1), .chan2_mode(mode2),
    .chan1_compare_value(c1), .chan1_reload_value(r1), .chan2_compare_value(c2),
    .chan2_reload_value(r2), .chan1_enable_clear(clr1), .chan1_enable_set(set1),
    .chan2_enable_clear(clr2), .chan1_comparator_active(act1), .chan2_comparator_active(act2));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk_value(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR time=%0t got=%h expected=%h", $time, got, exp);
    end
  endtask : chk_value
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_value({8'h00, got}, {8'h00, exp});
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    chk_value({15'h0000, got}, {15'h0000, exp});
  endtask : chk_flag
  task automatic chk_all;
    chk_value(c1, cmp[0]);
    chk_value(r1, rld[0]);
    chk_value(c2, cmp[1]);
    chk_value(r2, rld[1]);
  endtask : chk_all
  // bus tasks start and end just after a rising edge; one idle edge after the
  // strobe drops, so a following call never re-raises it in the same step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d, input logic [2:0] p);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    #1 chk_value({13'h0000, clr2, set1, clr1}, {13'h0000, p});
    @(posedge ref_clk);
    #1 req.wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] d, input logic h);
    req.rd = 1'b1;
    req.addr = a;
    @(posedge ref_clk);
    #1 req.rd = 1'b0;
    chk_byte(rsp.rdata, d);
    chk_flag(rsp.hit, h);
    @(posedge ref_clk);
    #1;
  endtask : sfr_read
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // the whole run is about 85 cycles; allow well over that
  initial
  begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    rvs = 1'b0;
    mode1 = 8'h00;
    mode2 = 8'h00;
    req = '0;
    cmp = '{16'h0000, 16'h0000};
    rld = '{16'h0000, 16'h0000};
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk_all();
    foreach (rows[i]) sfr_read(rows[i].addr, BYTE_RESET, 1'b1);
    $display("reset values done");
    foreach (rows[i])
    begin
      rvs = rows[i].rvs;
      mode1 = rows[i].mode;
      mode2 = rows[i].mode;
      view = rvs & mode1[PWM_ENABLE_BIT] & ~mode1[WIDE_PWM_SELECT_BIT];
      hi = rows[i].addr == CHAN1_VALUE_HIGH_ADDR;
      idx = (rows[i].addr == CHAN2_VALUE_LOW_ADDR) ? 1 : 0;
      if (view)
        rld[idx] = hi ? {rows[i].data, rld[idx][7:0]} : {rld[idx][15:8], rows[i].data};
      else
        cmp[idx] = hi ? {rows[i].data, cmp[idx][7:0]} : {cmp[idx][15:8], rows[i].data};
      sfr_write(rows[i].addr, rows[i].data, rows[i].pulses);
      chk_all();
      chk_flag(act1, mode1[COMPARATOR_ENABLE_BIT]);
      chk_flag(act2, mode2[COMPARATOR_ENABLE_BIT]);
      sfr_read(rows[i].addr, rows[i].data, 1'b1);
    end
    $display("table done");
    rvs = 1'b0;
    mode1 = 8'h00;
    sfr_write(8'hEC, 8'h77, 3'h0);
    chk_all();
    sfr_read(8'hEC, 8'h00, 1'b0);
    $display("unmapped address done");
    // low then high back to back, strobe held across both
    req.wr = 1'b1;
    req.addr = CHAN1_VALUE_LOW_ADDR;
    req.wdata = 8'h12;
    #1 chk_flag(clr1, 1'b1);
    @(posedge ref_clk);
    #1 req.addr = CHAN1_VALUE_HIGH_ADDR;
    req.wdata = 8'h34;
    #1 chk_flag(set1, 1'b1);
    @(posedge ref_clk);
    #1 req.wr = 1'b0;
    cmp[0] = 16'h3412;
    chk_all();
    $display("back to back done");
    // read and write in one cycle: the read returns the old byte
    @(posedge ref_clk);
    #1 req.wr = 1'b1;
    req.rd = 1'b1;
    req.addr = CHAN2_VALUE_LOW_ADDR;
    req.wdata = 8'h99;
    @(posedge ref_clk);
    #1 req.wr = 1'b0;
    req.rd = 1'b0;
    chk_byte(rsp.rdata, cmp[1][7:0]);
    cmp[1][7:0] = 8'h99;
    chk_all();
    $display("read with write done");
    rst_n = 1'b0;
    cmp = '{16'h0000, 16'h0000};
    rld = '{16'h0000, 16'h0000};
    #1 chk_all();
    @(posedge ref_clk);
    #1 rst_n = 1'b1;
    sfr_read(CHAN1_VALUE_HIGH_ADDR, BYTE_RESET, 1'b1);
    $display("second reset done");
    wrap_up();
  end
endmodule : pcacv_top_tb
